// *** hw/shsc_pkg.sv ***
// shared constants and types of the standby halt/stop controller
// assumes one 50 MHz clock and a core that pulses its instruction events
package shsc_pkg;

    // gray coded along run -> stop -> settle and run -> halt
    typedef enum logic [1:0] {
        SHSC_RUN    = 2'b00,
        SHSC_STOP   = 2'b01,
        SHSC_SETTLE = 2'b11,
        SHSC_HALT   = 2'b10
    } shsc_state_e;

    // standby instruction operands
    localparam logic [3:0]  SHSC_OP_TIMER = 4'h2;
    localparam logic [3:0]  SHSC_OP_KEY   = 4'h8;

    // request flag positions, lowest index is highest priority
    localparam int          SHSC_NFLG     = 3;
    localparam int          SHSC_FLG_TM   = 0;
    localparam int          SHSC_FLG_EXT  = 1;
    localparam int          SHSC_FLG_BTM  = 2;
    localparam logic [2:0]  SHSC_FLG_RST  = 3'h0;

    // interrupt vector addresses
    localparam logic [15:0] SHSC_VEC_TM   = 16'h0004;
    localparam logic [15:0] SHSC_VEC_EXT  = 16'h0003;
    localparam logic [15:0] SHSC_VEC_BTM  = 16'h0002;
    localparam logic [15:0] SHSC_VEC_NONE = 16'h0000;

    // settling timer tick: 64 us at the 50 MHz block clock
    localparam int          SHSC_CLK_MHZ  = 50;
    localparam int          SHSC_TICK_US  = 64;
    localparam int          SHSC_TICK_CYC = SHSC_TICK_US * SHSC_CLK_MHZ;
    localparam int          SHSC_PRE_W    = 12;
    localparam logic [7:0]  SHSC_CNT_RST  = 8'h00;

endpackage

// *** hw/shsc_key_if.sv ***
// key and matrix port levels with their wake evaluation result
// assumes all levels are synchronous to the block clock
`timescale 1ns/1ps
interface shsc_key_if;
    logic [3:0]  port_a;
    logic [3:0]  port_b;
    logic [3:0]  port_c;
    logic [3:0]  port_d;
    logic [11:0] bcd_is_input;
    logic [3:0]  port_e;
    logic        e_enable;
    logic [2:0]  port_f;
    logic        port_g;
    logic        fg_enable;
    logic        clear_level;
    logic        key_active;
    logic        key_idle;

    modport src (
        output port_a, port_b, port_c, port_d, bcd_is_input,
        output port_e, e_enable, port_f, port_g, fg_enable, clear_level,
        input  key_active, key_idle
    );
    modport eval (
        input  port_a, port_b, port_c, port_d, bcd_is_input,
        input  port_e, e_enable, port_f, port_g, fg_enable, clear_level,
        output key_active, key_idle
    );
endinterface

// *** hw/shsc_key_eval.sv ***
// combinational key-port wake detector
// assumes the pins are levels; works with the oscillator stopped
`timescale 1ns/1ps
module shsc_key_eval
    import shsc_pkg::*;
(
    shsc_key_if.eval k
);
    logic [11:0] bcd_lvl;
    logic        a_low;
    logic        bcd_low;
    logic        e_low;
    logic        fg_clr;

    assign bcd_lvl = {k.port_d, k.port_c, k.port_b};
    assign a_low   = ~&k.port_a;
    assign bcd_low = |(k.bcd_is_input & ~bcd_lvl);
    assign e_low   = k.e_enable & ~&k.port_e;
    // matrix F and G inputs wake when they sit at the clear level
    assign fg_clr  = k.fg_enable &
                     (|({k.port_g, k.port_f} ~^ {4{k.clear_level}}));

    assign k.key_active = a_low | bcd_low | e_low | fg_clr;
    assign k.key_idle   = ~k.key_active;
endmodule

// *** hw/shsc_timer.sv ***
// 8-bit modulo timer with a 64 us prescaler
// assumes restart is a one-cycle pulse from the controller
`timescale 1ns/1ps
module shsc_timer
    import shsc_pkg::*;
#(
    parameter int TICK_CYCLES = SHSC_TICK_CYC
) (
    input  wire logic       mclk,
    input  wire logic       arst_n,
    input  wire logic       restart,
    input  wire logic       run,
    input  wire logic [7:0] modulo,
    output logic            match_q
);
    localparam logic [SHSC_PRE_W-1:0] PRE_LAST =
        SHSC_PRE_W'(TICK_CYCLES - 1);
    localparam logic [SHSC_PRE_W-1:0] PRE_ZERO = '0;

    logic [SHSC_PRE_W-1:0] pre_q;
    logic [7:0]            cnt_q;
    logic                  tick;

    assign tick = run & ~restart & (pre_q == PRE_LAST);

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            pre_q <= PRE_ZERO;
        end else if (restart || tick) begin
            pre_q <= PRE_ZERO;
        end else if (run) begin
            pre_q <= pre_q + 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_q <= SHSC_CNT_RST;
        end else if (restart) begin
            cnt_q <= SHSC_CNT_RST;
        end else if (tick) begin
            cnt_q <= (cnt_q == modulo) ? SHSC_CNT_RST : cnt_q + 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            match_q <= 1'b0;
        end else begin
            match_q <= tick & (cnt_q == modulo);
        end
    end

    property p_tmr_match;
        @(posedge mclk) disable iff (!arst_n)
        match_q |-> $past(cnt_q) == $past(modulo) && cnt_q == SHSC_CNT_RST;
    endproperty
    a_tmr_match: assert property (p_tmr_match)
        else $error("timer match without counter equal to modulo");
endmodule

// *** hw/shsc_top.sv ***
// standby controller: halt, stop, settling wait and interrupt gating
// assumes instruction events are one-cycle pulses from the core
`timescale 1ns/1ps
module shsc_top
    import shsc_pkg::*;
#(
    parameter int TICK_CYCLES = SHSC_TICK_CYC
) (
    input  wire logic        mclk,
    input  wire logic        arst_n,
    input  wire logic        instr_end,
    input  wire logic        instr_halt,
    input  wire logic        instr_stop,
    input  wire logic [3:0]  instr_operand,
    input  wire logic        unmask_all_instr,
    input  wire logic        mask_all_instr,
    input  wire logic        timer_source_enable,
    input  wire logic        interval_source_enable,
    input  wire logic        ext_pin_source_enable,
    input  wire logic        timer_run_enable,
    input  wire logic [7:0]  timer_modulo_value,
    input  wire logic        interval_event,
    input  wire logic        int_pin,
    input  wire logic        int_pin_select,
    input  wire logic        int_edge_falling,
    input  wire logic        flag_wr,
    input  wire logic [2:0]  flag_wdata,
    input  wire logic [3:0]  key_port_a,
    input  wire logic [3:0]  key_port_b,
    input  wire logic [3:0]  key_port_c,
    input  wire logic [3:0]  key_port_d,
    input  wire logic [11:0] key_bcd_is_input,
    input  wire logic [3:0]  matrix_port_e,
    input  wire logic        matrix_e_enable,
    input  wire logic [2:0]  matrix_port_f,
    input  wire logic        matrix_port_g,
    input  wire logic        matrix_fg_enable,
    input  wire logic        matrix_clear_level,
    output logic             cpu_hold_q,
    output logic             osc_run_q,
    output logic             interval_run_q,
    output logic             resume_q,
    output logic             nop_q,
    output logic             irq_take_q,
    output logic [15:0]      irq_vector_q,
    output logic             timer_request_flag_q,
    output logic             ext_pin_request_flag_q,
    output logic             interval_request_flag_q,
    output logic             global_irq_enable_q
);
    shsc_key_if keys ();

    shsc_state_e           state_q;
    shsc_state_e           state_d;
    logic [3:0]            op_q;
    logic [SHSC_NFLG-1:0]  flag_q;
    logic [SHSC_NFLG-1:0]  flag_set;
    logic [SHSC_NFLG-1:0]  flag_clr;
    logic [SHSC_NFLG-1:0]  src_en;
    logic [SHSC_NFLG-1:0]  pend_en;
    logic [SHSC_NFLG-1:0]  take_sel;
    logic                  ei_wait_q;
    logic                  int_prev_q;
    logic                  int_armed_q;
    logic                  int_edge;
    logic                  ack_ok;
    logic                  tm_match;
    logic                  tmr_restart;
    logic                  halt_ok;
    logic                  stop_ok;
    logic                  halt_wake;
    logic                  halt_vec;
    logic                  stop_wake;
    logic                  take_run;
    logic                  take;
    logic                  resume;
    logic                  nop;
    logic [15:0]           vec_d;

    assign keys.port_a       = key_port_a;
    assign keys.port_b       = key_port_b;
    assign keys.port_c       = key_port_c;
    assign keys.port_d       = key_port_d;
    assign keys.bcd_is_input = key_bcd_is_input;
    assign keys.port_e       = matrix_port_e;
    assign keys.e_enable     = matrix_e_enable;
    assign keys.port_f       = matrix_port_f;
    assign keys.port_g       = matrix_port_g;
    assign keys.fg_enable    = matrix_fg_enable;
    assign keys.clear_level  = matrix_clear_level;

    shsc_key_eval u_keys (
        .k (keys)
    );

    shsc_timer #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_timer (
        .mclk    (mclk),
        .arst_n  (arst_n),
        .restart (tmr_restart),
        .run     (osc_run_q & (timer_run_enable | state_q == SHSC_SETTLE)),
        .modulo  (timer_modulo_value),
        .match_q (tm_match)
    );

    assign src_en[SHSC_FLG_TM]  = timer_source_enable;
    assign src_en[SHSC_FLG_EXT] = ext_pin_source_enable;
    assign src_en[SHSC_FLG_BTM] = interval_source_enable;
    assign pend_en              = flag_q & src_en;

    // interrupt pin edge on the selected polarity, none before first sample
    assign int_edge = int_pin_select & int_armed_q &
                      (int_edge_falling ? (int_prev_q & ~int_pin)
                                        : (~int_prev_q & int_pin));

    assign ack_ok = global_irq_enable_q & ~ei_wait_q & ~unmask_all_instr;

    always_comb begin
        halt_ok = 1'b0;
        if (instr_operand == SHSC_OP_TIMER) begin
            halt_ok = ~flag_q[SHSC_FLG_TM];
        end else if (instr_operand == SHSC_OP_KEY) begin
            halt_ok = ~|pend_en & keys.key_idle;
        end
    end

    assign stop_ok = (instr_operand == SHSC_OP_KEY) & keys.key_idle &
                     ~pend_en[SHSC_FLG_EXT];

    assign stop_wake = keys.key_active | pend_en[SHSC_FLG_EXT];

    always_comb begin
        halt_wake = 1'b0;
        halt_vec  = 1'b0;
        if (op_q == SHSC_OP_TIMER) begin
            halt_wake = flag_q[SHSC_FLG_TM];
            halt_vec  = global_irq_enable_q & pend_en[SHSC_FLG_TM];
        end else if (keys.key_active) begin
            halt_wake = 1'b1;
        end else if (|pend_en) begin
            halt_wake = 1'b1;
            halt_vec  = global_irq_enable_q;
        end
    end

    assign take_run = (state_q == SHSC_RUN) & instr_end & ack_ok &
                      (|pend_en) & ~instr_halt & ~instr_stop;
    assign take     = take_run |
                      ((state_q == SHSC_HALT) & halt_wake & halt_vec);

    always_comb begin
        take_sel = '0;
        vec_d    = SHSC_VEC_NONE;
        if (pend_en[SHSC_FLG_TM]) begin
            take_sel[SHSC_FLG_TM] = 1'b1;
            vec_d                 = SHSC_VEC_TM;
        end else if (pend_en[SHSC_FLG_EXT]) begin
            take_sel[SHSC_FLG_EXT] = 1'b1;
            vec_d                  = SHSC_VEC_EXT;
        end else if (pend_en[SHSC_FLG_BTM]) begin
            take_sel[SHSC_FLG_BTM] = 1'b1;
            vec_d                  = SHSC_VEC_BTM;
        end
    end

    always_comb begin
        state_d     = state_q;
        resume      = 1'b0;
        nop         = 1'b0;
        tmr_restart = 1'b0;
        case (state_q)
            SHSC_RUN: begin
                if (instr_halt) begin
                    if (halt_ok) begin
                        state_d = SHSC_HALT;
                    end else begin
                        nop = 1'b1;
                    end
                end else if (instr_stop) begin
                    if (stop_ok) begin
                        state_d = SHSC_STOP;
                    end else begin
                        nop = 1'b1;
                    end
                end
            end
            SHSC_HALT: begin
                if (halt_wake) begin
                    state_d = SHSC_RUN;
                    resume  = ~halt_vec;
                end
            end
            SHSC_STOP: begin
                if (stop_wake) begin
                    state_d     = SHSC_SETTLE;
                    tmr_restart = 1'b1;
                end
            end
            SHSC_SETTLE: begin
                if (tm_match) begin
                    state_d = SHSC_RUN;
                    resume  = 1'b1;
                end
            end
            default: begin
                state_d = SHSC_RUN;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= SHSC_RUN;
            op_q    <= SHSC_OP_KEY;
        end else begin
            state_q <= state_d;
            if (state_q == SHSC_RUN && instr_halt) begin
                op_q <= instr_operand;
            end else if (state_q == SHSC_STOP) begin
                op_q <= SHSC_OP_TIMER;
            end
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            cpu_hold_q     <= 1'b0;
            osc_run_q      <= 1'b1;
            interval_run_q <= 1'b1;
            resume_q       <= 1'b0;
            nop_q          <= 1'b0;
            irq_take_q     <= 1'b0;
            irq_vector_q   <= SHSC_VEC_NONE;
        end else begin
            cpu_hold_q     <= state_d != SHSC_RUN;
            osc_run_q      <= state_d != SHSC_STOP;
            interval_run_q <= state_d != SHSC_STOP;
            resume_q       <= resume;
            nop_q          <= nop;
            irq_take_q     <= take;
            irq_vector_q   <= take ? vec_d : SHSC_VEC_NONE;
        end
    end

    // request flag events; the stopped clock holds back the timers
    assign flag_set[SHSC_FLG_TM]  = tm_match;
    assign flag_set[SHSC_FLG_EXT] = int_edge;
    assign flag_set[SHSC_FLG_BTM] = interval_event & osc_run_q;
    assign flag_clr = (take ? take_sel : '0) |
                      (flag_wr ? ~flag_wdata : '0) |
                      (tmr_restart ? (3'h1 << SHSC_FLG_TM) : '0);

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            flag_q <= SHSC_FLG_RST;
        end else begin
            flag_q <= (flag_q & ~flag_clr) | flag_set |
                      (flag_wr ? flag_wdata : '0);
        end
    end

    assign timer_request_flag_q    = flag_q[SHSC_FLG_TM];
    assign ext_pin_request_flag_q  = flag_q[SHSC_FLG_EXT];
    assign interval_request_flag_q = flag_q[SHSC_FLG_BTM];

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            int_prev_q  <= 1'b0;
            int_armed_q <= 1'b0;
        end else begin
            int_prev_q  <= int_pin;
            int_armed_q <= 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            global_irq_enable_q <= 1'b0;
            ei_wait_q           <= 1'b0;
        end else begin
            if (mask_all_instr || take) begin
                global_irq_enable_q <= 1'b0;
            end else if (unmask_all_instr) begin
                global_irq_enable_q <= 1'b1;
            end
            if (unmask_all_instr) begin
                ei_wait_q <= 1'b1;
            end else if (instr_end) begin
                ei_wait_q <= 1'b0;
            end
        end
    end

    property p_ei_hold;
        @(posedge mclk) disable iff (!arst_n)
        (ei_wait_q || unmask_all_instr) |=> !irq_take_q;
    endproperty
    a_ei_hold: assert property (p_ei_hold)
        else $error("interrupt taken right after unmask");

    property p_halt_clk;
        @(posedge mclk) disable iff (!arst_n)
        (state_q == SHSC_HALT) |-> cpu_hold_q && osc_run_q;
    endproperty
    a_halt_clk: assert property (p_halt_clk)
        else $error("halt without hold or with clock off");

    property p_stop_hold;
        @(posedge mclk) disable iff (!arst_n)
        (state_q == SHSC_STOP && !stop_wake) |=>
            state_q == SHSC_STOP && !osc_run_q;
    endproperty
    a_stop_hold: assert property (p_stop_hold)
        else $error("stop left without wake");

    property p_tm_entry;
        @(posedge mclk) disable iff (!arst_n)
        (state_q == SHSC_RUN && instr_halt &&
         instr_operand == SHSC_OP_TIMER && !flag_q[SHSC_FLG_TM]) |=>
            state_q == SHSC_HALT && cpu_hold_q;
    endproperty
    a_tm_entry: assert property (p_tm_entry)
        else $error("timer halt not entered");

    property p_key_nop;
        @(posedge mclk) disable iff (!arst_n)
        (state_q == SHSC_RUN && instr_halt &&
         instr_operand == SHSC_OP_KEY && keys.key_active) |=>
            nop_q && state_q == SHSC_RUN;
    endproperty
    a_key_nop: assert property (p_key_nop)
        else $error("key halt entered with a pin low");

    property p_pin_wake;
        @(posedge mclk) disable iff (!arst_n)
        (state_q == SHSC_HALT && op_q == SHSC_OP_KEY && keys.key_active)
            |=> resume_q && !irq_take_q && state_q == SHSC_RUN;
    endproperty
    a_pin_wake: assert property (p_pin_wake)
        else $error("pin wake did not resume after halt");

    property p_tm_vec;
        @(posedge mclk) disable iff (!arst_n)
        (state_q == SHSC_HALT && op_q == SHSC_OP_TIMER &&
         pend_en[SHSC_FLG_TM] && global_irq_enable_q) |=>
            irq_take_q && irq_vector_q == SHSC_VEC_TM;
    endproperty
    a_tm_vec: assert property (p_tm_vec)
        else $error("timer halt did not vector");

    property p_stop_rel;
        @(posedge mclk) disable iff (!arst_n)
        (state_q == SHSC_STOP && stop_wake) |=>
            state_q == SHSC_SETTLE && osc_run_q && !flag_q[SHSC_FLG_TM];
    endproperty
    a_stop_rel: assert property (p_stop_rel)
        else $error("stop release sequence wrong");

    property p_settle_end;
        @(posedge mclk) disable iff (!arst_n)
        (state_q == SHSC_SETTLE && tm_match) |=>
            resume_q && state_q == SHSC_RUN && flag_q[SHSC_FLG_TM];
    endproperty
    a_settle_end: assert property (p_settle_end)
        else $error("settling wait did not end on match");

    property p_prio;
        @(posedge mclk) disable iff (!arst_n)
        (irq_take_q && irq_vector_q != SHSC_VEC_TM) |->
            !$past(pend_en[SHSC_FLG_TM]);
    endproperty
    a_prio: assert property (p_prio)
        else $error("lower priority taken over timer");

    property p_set_wins;
        @(posedge mclk) disable iff (!arst_n)
        (int_edge && flag_wr && !flag_wdata[SHSC_FLG_EXT]) |=>
            flag_q[SHSC_FLG_EXT];
    endproperty
    a_set_wins: assert property (p_set_wins)
        else $error("pin request lost against software clear");
endmodule

// *** verification/shsc_core_model.sv ***
// core stand-in: ends one instruction per bench step while cpu_hold_q is low
// assumes step is a one-cycle level from the bench
`timescale 1ns/1ps
module shsc_core_model (
    input  wire logic step,
    input  wire logic cpu_hold_q,
    output logic      instr_end
);
    assign instr_end = step & ~cpu_hold_q;
endmodule

// *** verification/standby_halt_stop_control_bench.sv ***
// bench for the standby controller, expected events in a queue
// assumes the top and the core stand-in compile before it
`timescale 1ns/1ps
module standby_halt_stop_control_bench;
    import shsc_pkg::*;
    localparam int T = 4;
    localparam logic [2:0] R = 3'h4, N = 3'h2, I = 3'h1;
    logic mclk = 0, arst_n = 0, step = 0, instr_end, instr_halt = 0;
    logic instr_stop = 0, unmask_all_instr = 0, mask_all_instr = 0;
    logic timer_source_enable = 0, interval_source_enable = 0;
    logic ext_pin_source_enable = 0, timer_run_enable = 0;
    logic interval_event = 0, int_pin = 1, int_pin_select = 1;
    logic int_edge_falling = 1, flag_wr = 0, matrix_e_enable = 1;
    logic matrix_port_g = 0, matrix_fg_enable = 1, matrix_clear_level = 1;
    logic [3:0] instr_operand = 4'h0, key_port_a = 4'hF, key_port_b = 4'hF;
    logic [3:0] key_port_c = 4'hF, key_port_d = 4'hF, matrix_port_e = 4'hF;
    logic [2:0] flag_wdata = 3'h0, matrix_port_f = 3'h0;
    logic [7:0] timer_modulo_value = 8'h01;
    logic [11:0] key_bcd_is_input = 12'hFFF;
    logic cpu_hold_q, osc_run_q, interval_run_q, resume_q, nop_q, irq_take_q;
    logic timer_request_flag_q, ext_pin_request_flag_q;
    logic interval_request_flag_q, global_irq_enable_q;
    logic [15:0] irq_vector_q;
    logic [18:0] q[$];
    logic [31:0] lf = 32'h789B;
    int mismatches = 0, n_compared = 0, cyc = 0, n;

    shsc_top #(.TICK_CYCLES(T)) i_dut (.*);
    shsc_core_model i_core (.step(step), .cpu_hold_q(cpu_hold_q),
                            .instr_end(instr_end));

    always #10 mclk = ~mclk;

    function automatic logic [31:0] rnd();
        lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
        return lf;
    endfunction
    task automatic chk(string s, logic [18:0] v, logic [18:0] e);
        n_compared++;
        if (v !== e) begin
            mismatches++;
            $display("BAD %s exp %h seen %h", s, e, v);
        end
    endtask
    task automatic end_sim();
        if (mismatches == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic tick(int k);
        repeat (k) @(negedge mclk);
    endtask
    task automatic sb(logic h, logic [3:0] op, logic [2:0] k, logic [15:0] v);
        q.push_back({k, v});
        instr_halt = h;
        instr_stop = ~h;
        instr_operand = op;
        tick(1);
        instr_halt = 0;
        instr_stop = 0;
        tick(1);
    endtask
    task automatic st(logic um);
        step = 1;
        unmask_all_instr = um;
        tick(1);
        step = 0;
        unmask_all_instr = 0;
        tick(1);
    endtask
    task automatic fw(logic [2:0] d);
        flag_wr = 1;
        flag_wdata = d;
        tick(1);
        flag_wr = 0;
        tick(2);
    endtask
    task automatic drain();
        for (int i = 0; i < 3000 && q.size() != 0; i++) tick(1);
        chk("pending", 19'(q.size()), 19'h0);
    endtask

    always @(posedge mclk) begin
        #1;
        if (resume_q | nop_q | irq_take_q)
            chk("event", {resume_q, nop_q, irq_take_q, irq_vector_q},
                q.size() != 0 ? q.pop_front() : 19'h7FFFF);
    end
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 30000) begin
            mismatches++;
            end_sim();
        end
    end

    initial begin
        tick(16);
        arst_n = 1;
        tick(2);
        for (int i = 0; i < 4; i++) sb(i[0], 4'(rnd() | 1), N, 0);
        for (int k = 0; k < 4; k++) begin
            sb(1, SHSC_OP_KEY, R, 0);
            tick(3);
            chk("hold", cpu_hold_q & osc_run_q, 1);
            n = rnd() % 4;
            case (k)
                0: key_port_a[n] = 0;
                1: key_port_b[n] = 0;
                2: matrix_port_e[n] = 0;
                default: matrix_port_g = 1;
            endcase
            tick(3);
            {key_port_a, key_port_b, matrix_port_e, matrix_port_g} = 13'h1FFE;
            tick(1);
        end
        ext_pin_source_enable = 1;
        fw(3'h2);
        sb(1, SHSC_OP_KEY, N, 0);
        sb(0, SHSC_OP_KEY, N, 0);
        ext_pin_source_enable = 0;
        fw(3'h0);
        key_port_d = 4'hE;
        sb(1, SHSC_OP_KEY, N, 0);
        sb(0, SHSC_OP_KEY, N, 0);
        key_port_d = 4'hF;
        sb(1, SHSC_OP_KEY, R, 0);
        interval_event = 1;
        tick(1);
        interval_event = 0;
        tick(4);
        chk("held", {cpu_hold_q, interval_request_flag_q}, 3);
        interval_source_enable = 1;
        drain();
        interval_source_enable = 0;
        fw(3'h0);
        timer_modulo_value = 8'(rnd() % 7 + 1);
        sb(1, SHSC_OP_TIMER, R, 0);
        timer_run_enable = 1;
        chk("thold", cpu_hold_q, 1);
        drain();
        sb(1, SHSC_OP_TIMER, N, 0);
        timer_run_enable = 0;
        fw(3'h0);
        for (int k = 0; k < 2; k++) begin
            ext_pin_source_enable = k[0];
            sb(0, SHSC_OP_KEY, R, 0);
            tick(4);
            chk("osc", {osc_run_q, interval_run_q}, 0);
            if (k == 1) int_pin = 0;
            else key_port_c[rnd() % 4] = 0;
            tick(4);
            chk("wake", {osc_run_q, interval_run_q, timer_request_flag_q,
                cpu_hold_q}, 4'hD);
            for (n = 4; cpu_hold_q === 1 && n < 3000; n++) tick(1);
            chk("settle", n >= (timer_modulo_value + 1) * T &&
                n <= (timer_modulo_value + 1) * T + 4, 1);
            drain();
            key_port_c = 4'hF;
            int_pin = 1;
            fw(3'h0);
        end
        int_pin = 0;
        fw(3'h0);
        chk("setwin", ext_pin_request_flag_q, 1);
        int_pin = 1;
        {timer_source_enable, ext_pin_source_enable,
            interval_source_enable} = 3'h7;
        fw(3'h7);
        for (int i = 0; i < 3; i++) begin
            q.push_back({I, i == 0 ? SHSC_VEC_TM : i == 1 ? SHSC_VEC_EXT
                : SHSC_VEC_BTM});
            st(1);
            st(0);
            chk("early", global_irq_enable_q, 1);
            st(0);
            tick(1);
        end
        drain();
        chk("flags", {timer_request_flag_q, ext_pin_request_flag_q,
            interval_request_flag_q}, 0);
        st(1);
        mask_all_instr = 1;
        tick(1);
        mask_all_instr = 0;
        chk("mask", global_irq_enable_q, 0);
        st(1);
        st(0);
        sb(1, SHSC_OP_TIMER, I, SHSC_VEC_TM);
        timer_run_enable = 1;
        drain();
        end_sim();
    end
endmodule
